// ### bench/bilge_setup_props.sv
// Purpose: Port checks for bilge_setup
// Assumes: Key presses last at least four cycles
// Notes:   Bound from the bench top file
`timescale 1ns/100ps
`default_nettype none
module bilge_setup_props
	import bilge_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES = 30
) (
	input wire logic           i_clock,
	input wire logic           i_arst_n,
	input wire keys_s          i_keys,
	input wire logic [NCH-1:0] i_sensor,
	input wire logic [NCH-1:0] i_manual_pump,
	input wire logic           i_sense_jumper,
	input wire logic [NCH-1:0] o_pump_on,
	input wire logic [NCH-1:0] o_pump_fault,
	input wire logic [NCH-1:0] o_run_alarm,
	input wire logic           o_alarm,
	input wire logic           o_program_mode,
	input wire menu_e          o_menu_state,
	input wire logic [3:0]     o_cur_addr,
	input wire logic           o_nvm_save
);
	logic [31:0] held_q;
	logic [3:0]  jmp_q;
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			held_q <= '0;
			jmp_q  <= '0;
		end else begin
			held_q <= (i_keys.mute && i_keys.up) ? held_q + 32'h1 : '0;
			jmp_q  <= !i_sense_jumper ? '0 : (jmp_q == 4'h8 ? jmp_q : jmp_q + 4'h1);
		end
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	sequence s_mute_press;
		!i_keys.mute ##1 i_keys.mute [*4];
	endsequence
	sequence s_new_fault;
		(o_pump_fault & ~$past(o_pump_fault)) != '0;
	endsequence
	entry_after_hold_a: assert property ($rose(o_program_mode) |-> held_q >= HOLD_CYCLES)
		else $error("program mode without full hold");
	fault_when_cmd_a: assert property ((o_pump_fault & ~$past(o_pump_fault) & ~o_pump_on) == '0)
		else $error("fault on idle pump");
	fault_alarm_a: assert property (s_new_fault |-> ##[0:1] o_alarm)
		else $error("fault without alarm");
	mute_quiet_a: assert property (s_mute_press |-> ##[0:3] !o_alarm)
		else $error("mute left alarm on");
	jumper_no_fault_a: assert property (jmp_q == 4'h8 |-> o_pump_fault == '0)
		else $error("fault with check off");
	auto_on_wet_a: assert property ((o_pump_on & ~$past(o_pump_on) & ~$past(i_manual_pump, 2)
		& ~$past(i_sensor, 4)) == '0)
		else $error("pump on while dry");
	auto_off_dry_a: assert property ((~o_pump_on & $past(o_pump_on) & ~$past(i_manual_pump, 6)
		& $past(i_sensor, 4)) == '0)
		else $error("pump off while wet");
	run_alarm_pump_a: assert property ((o_run_alarm & ~$past(o_run_alarm) & ~o_pump_on) == '0)
		else $error("run alarm on idle pump");
	save_pulse_a: assert property (o_nvm_save |-> ##1 !o_nvm_save ##[0:1] !o_program_mode)
		else $error("bad save pulse");
	addr_range_a: assert property (o_cur_addr >= MIN_ADDR && o_cur_addr <= MAX_ADDR)
		else $error("address out of range");
endmodule
`default_nettype wire

// ### bench/bilge_setup_test.sv
// Purpose: Self-checking bench for bilge_setup
// Assumes: Short second and hold parameters
// Notes:   One task a scenario
`timescale 1ns/100ps
`default_nettype none
module bilge_setup_test;
	import bilge_pkg::*;
	localparam keys_s K_MUTE = 6'h20;
	localparam keys_s K_UP   = 6'h10;
	localparam keys_s K_DOWN = 6'h08;
	localparam keys_s K_PUMP = 6'h04;
	localparam keys_s K_DUP  = 6'h02;
	logic           i_clock = 1'b0;
	logic           i_arst_n = 1'b0;
	keys_s          keys = '0;
	logic [NCH-1:0] sensor = '0, manual = '0, broken = '0, cur_ok, pump_on, fault, run_al;
	logic           jumper = 1'b0, alarm, prog, save, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic           pready, pslverr, err;
	menu_e          state;
	logic [1:0]     item;
	logic [2:0]     epos;
	logic [3:0]     addr;
	logic [7:0]     paddr = '0;
	logic [31:0]    pwdata = '0, prdata, rd;
	int             n_fail = 0, checks = 0, saves = 0;
	always #2.5 i_clock = ~i_clock;
	always @(posedge i_clock) if (save === 1'b1) saves++;
	bilge_units_model unit_u (.i_pump_on(pump_on), .i_broken(broken), .o_current_ok(cur_ok));
	bilge_setup #(.SEC_CYCLES(10), .HOLD_CYCLES(30)) dut_u (
		.i_clock(i_clock), .i_arst_n(i_arst_n), .i_keys(keys), .i_sensor(sensor),
		.i_current_ok(cur_ok), .i_manual_pump(manual), .i_sense_jumper(jumper),
		.o_pump_on(pump_on), .o_pump_fault(fault), .o_run_alarm(run_al), .o_alarm(alarm),
		.o_program_mode(prog), .o_menu_state(state), .o_menu_item(item), .o_cur_addr(addr),
		.o_edit_pos(epos), .o_nvm_save(save), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	// ---
	// Shared tasks
	// ---
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
	endtask
	task automatic press(input keys_s k, input int n);
		@(posedge i_clock);
		keys <= k;
		cyc(n);
		keys <= '0;
		cyc(6);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clock);
		penable <= 1'b1;
		forever begin
			@(posedge i_clock);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_cfg(input logic [2:0] idx);
		apb(1'b1, REG_CHSEL, {29'h0, idx});
		apb(1'b0, REG_CHCFG, '0);
	endtask
	task automatic pick(input logic [1:0] t);
		repeat (4) if (item !== t) press(K_DOWN, 4);
		press(K_MUTE, 4);
	endtask
	task automatic seek(input logic [3:0] t);
		repeat (8) if (addr < t) press(K_UP, 4);
		repeat (8) if (addr > t) press(K_DOWN, 4);
	endtask
	// ---
	// Scenarios
	// ---
	task automatic t_entry();
		press(K_MUTE | K_UP, 20);
		chk(state, ST_MONITOR);
		press(K_MUTE | K_UP, 40);
		chk({state, prog, item}, {ST_MENU, 1'b1, ITEM_PROG});
		$display("entry done");
	endtask
	task automatic t_program();
		pick(ITEM_PROG);
		chk(state, ST_SEL_CH);
		seek(4'h2);
		press(K_DOWN, 4);
		chk(addr, 4'h2);
		press(K_UP, 4);
		chk(addr, 4'h3);
		press(K_MUTE, 4);
		press(K_UP, 4);
		press(K_PUMP, 4);
		chk(state, ST_EDIT_NAME);
		press(K_DUP, 4);
		chk(epos, 3'h1);
		press(K_UP, 4);
		press(K_MUTE, 4);
		chk(state, ST_ON_PROMPT);
		press(K_MUTE, 4);
		chk(state, ST_ON_EDIT);
		press(K_UP, 4);
		press(K_UP, 4);
		press(K_MUTE, 4);
		press(K_MUTE, 4);
		press(K_DOWN, 4);
		press(K_MUTE, 4);
		press(K_MUTE, 4);
		chk(state, ST_RUN_SEC);
		press(K_UP, 4);
		press(K_MUTE, 4);
		press(K_UP, 4);
		press(K_MUTE, 4);
		chk(state, ST_DONE);
		press(K_UP, 4);
		chk(state, ST_MENU);
		rd_cfg(3'h1);
		chk(rd, 32'h0185000a);
		chk(saves, 0);
		apb(1'b0, REG_STATUS, '0);
		chk(rd, 32'h000018d1);
		$display("program done");
	endtask
	task automatic t_defaults();
		pick(ITEM_PROG);
		seek(4'h2);
		press(K_MUTE, 4);
		press(K_MUTE, 4);
		press(K_DOWN, 4);
		chk(state, ST_DONE);
		press(K_DOWN, 4);
		chk({state, prog, saves[3:0]}, {ST_MONITOR, 1'b0, 4'h1});
		rd_cfg(3'h0);
		chk(rd, 32'h01800505);
		$display("defaults done");
	endtask
	task automatic t_pump();
		cyc(1);
		sensor[0] <= 1'b1;
		cyc(50);
		chk(pump_on[0], 1'b0);
		cyc(20);
		chk(pump_on[0], 1'b1);
		cyc(580);
		chk(run_al[0], 1'b0);
		cyc(70);
		chk({run_al[0], alarm}, 2'h3);
		press(K_MUTE, 4);
		chk(alarm, 1'b0);
		sensor[0] <= 1'b0;
		cyc(50);
		chk(pump_on[0], 1'b1);
		cyc(20);
		chk(pump_on[0], 1'b0);
		$display("pump done");
	endtask
	task automatic t_fault();
		cyc(1);
		broken[1] <= 1'b1;
		manual[1] <= 1'b1;
		cyc(10);
		chk(fault[1], 1'b0);
		cyc(30);
		chk({fault[1], alarm}, 2'h3);
		press(K_MUTE, 4);
		chk({fault[1], alarm}, 2'h2);
		jumper <= 1'b1;
		cyc(8);
		chk(fault[1], 1'b0);
		manual[1] <= 1'b0;
		cyc(4);
		manual[1] <= 1'b1;
		cyc(40);
		chk({fault[1], pump_on[1]}, 2'h1);
		manual[1] <= 1'b0;
		jumper <= 1'b0;
		$display("fault done");
	endtask
	task automatic t_erase();
		press(K_MUTE | K_UP, 40);
		pick(ITEM_SUB);
		press(K_MUTE, 4);
		chk(state, ST_SUB_MENU);
		pick(SUB_OFF);
		press(K_MUTE, 4);
		press(K_UP, 4);
		press(K_MUTE, 4);
		chk(state, ST_SUB_MENU);
		pick(SUB_EXIT);
		chk(state, ST_MENU);
		rd_cfg(3'h0);
		chk(rd, 32'h01800a05);
		for (int yes = 0; yes < 2; yes++) begin
			pick(ITEM_ERASE);
			seek(4'h3);
			press(K_MUTE, 4);
			chk(state, ST_ERASE_CONF);
			press(yes ? K_DOWN : K_UP, 4);
			chk(state, ST_MENU);
			rd_cfg(3'h1);
			chk(rd[23], !yes);
		end
		apb(1'b1, 8'h40, '1);
		chk(err, 1'b1);
		pick(ITEM_EXIT);
		chk({state, saves[3:0]}, {ST_MONITOR, 4'h2});
		$display("erase done");
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#300000;
		n_fail++;
		tally_and_finish();
	end
	initial begin
		cyc(4);
		i_arst_n <= 1'b1;
		t_entry();
		t_program();
		t_defaults();
		t_pump();
		t_fault();
		t_erase();
		tally_and_finish();
	end
endmodule
bind bilge_setup bilge_setup_props #(.HOLD_CYCLES(HOLD_CYCLES)) props_u (
	.i_clock(i_clock), .i_arst_n(i_arst_n), .i_keys(i_keys), .i_sensor(i_sensor),
	.i_manual_pump(i_manual_pump), .i_sense_jumper(i_sense_jumper), .o_pump_on(o_pump_on),
	.o_pump_fault(o_pump_fault), .o_run_alarm(o_run_alarm), .o_alarm(o_alarm),
	.o_program_mode(o_program_mode), .o_menu_state(o_menu_state), .o_cur_addr(o_cur_addr),
	.o_nvm_save(o_nvm_save));
`default_nettype wire

// ### bench/bilge_units_model.sv
// Purpose: Current sense of the pump-driving I/O units
// Assumes: A healthy pump draws current while driven
// Notes:   Broken slots never show current
`timescale 1ns/100ps
`default_nettype none
module bilge_units_model
	import bilge_pkg::*;
(
	input  wire logic [NCH-1:0] i_pump_on,
	input  wire logic [NCH-1:0] i_broken,
	output wire logic [NCH-1:0] o_current_ok
);
	// Slot k is the one unit at switch address k+2
	assign o_current_ok = i_pump_on & ~i_broken;
endmodule
`default_nettype wire

// ### design/bilge_pkg.sv
// Purpose: Shared constants, types and helpers for the bilge setup menu and pump checker
// Assumes: 200 MHz system clock, switch addresses 2..9 mapped to channel indices 0..7
// Notes:   Function list follows

package bilge_pkg;

	localparam int unsigned CLK_HZ     = 200_000_000;
	localparam int unsigned HOLD_S     = 3;
	localparam int unsigned SETTLE_S   = 2;
	localparam int unsigned NCH        = 8;
	localparam int unsigned NAME_LEN   = 8;

	localparam logic [7:0] STEP_S      = 8'h05;
	localparam logic [7:0] STEP_MIN    = 8'h01;
	localparam logic [7:0] DEF_ON_S    = 8'h05;
	localparam logic [7:0] DEF_OFF_S   = 8'h05;
	localparam logic [5:0] DEF_RUN_SEC = 6'h00;
	localparam logic [7:0] DEF_RUN_MIN = 8'h01;
	localparam logic [7:0] MAX_DLY     = 8'hff;
	localparam logic [5:0] MAX_RUN_SEC = 6'h37;
	localparam logic [3:0] MIN_ADDR    = 4'h2;
	localparam logic [3:0] MAX_ADDR    = 4'h9;
	localparam logic [3:0] LAST_PRESET = 4'he;
	localparam logic [2:0] LAST_POS    = 3'h7;
	localparam logic [13:0] SEC_PER_MIN = 14'h003c;

	// Menu entries
	localparam logic [1:0] ITEM_PROG  = 2'h0;
	localparam logic [1:0] ITEM_SUB   = 2'h1;
	localparam logic [1:0] ITEM_ERASE = 2'h2;
	localparam logic [1:0] ITEM_EXIT  = 2'h3;
	// Sub-menu entries
	localparam logic [1:0] SUB_ON     = 2'h0;
	localparam logic [1:0] SUB_OFF    = 2'h1;
	localparam logic [1:0] SUB_RUN    = 2'h2;
	localparam logic [1:0] SUB_EXIT   = 2'h3;

	// APB map
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_CHSEL  = 8'h04;
	localparam logic [7:0] REG_CHCFG  = 8'h08;
	localparam logic [7:0] REG_PUMPS  = 8'h0c;

	typedef enum logic [3:0] {
		ST_MONITOR    = 4'h0,
		ST_MENU       = 4'h1,
		ST_SEL_CH     = 4'h3,
		ST_SEL_NAME   = 4'h2,
		ST_EDIT_NAME  = 4'h6,
		ST_ON_PROMPT  = 4'h7,
		ST_ON_EDIT    = 4'h5,
		ST_OFF_PROMPT = 4'h4,
		ST_OFF_EDIT   = 4'hc,
		ST_RUN_PROMPT = 4'hd,
		ST_RUN_SEC    = 4'hf,
		ST_RUN_MIN    = 4'he,
		ST_DONE       = 4'ha,
		ST_ERASE_SEL  = 4'hb,
		ST_ERASE_CONF = 4'h9,
		ST_SUB_MENU   = 4'h8
	} menu_e;

	typedef struct packed {
		logic                    mute;
		logic                    up;
		logic                    down;
		logic                    pump;
		logic                    dim_up;
		logic                    dim_down;
	} keys_s;

	typedef struct packed {
		logic                    valid;
		logic [7:0]              on_s;
		logic [7:0]              off_s;
		logic [5:0]              run_sec;
		logic [7:0]              run_min;
		logic [3:0]              preset;
		logic                    custom;
		logic [NAME_LEN*6-1:0]   text;
	} chan_s;

	function automatic logic [2:0] chan_idx(input logic [3:0] addr);
		logic [3:0] d;
		d = addr - MIN_ADDR;
		return d[2:0];
	endfunction

	function automatic logic [7:0] sat_up(input logic [7:0] v, input logic [7:0] step, input logic [7:0] max);
		return (v > max - step) ? max : v + step;
	endfunction

	function automatic logic [7:0] sat_dn(input logic [7:0] v, input logic [7:0] step);
		return (v < step) ? 8'h00 : v - step;
	endfunction

endpackage

// ### design/bilge_setup.sv
// Purpose: Setup menu, working channel storage and per-channel pump timing and checking
// Assumes: Keys, sensors, current sense and jumper are asynchronous pins
// Notes:   APB slave answers with zero wait states
`timescale 1ns/100ps
`default_nettype none

module bilge_setup
	import bilge_pkg::*;
#(
	parameter int unsigned SEC_CYCLES  = CLK_HZ,
	parameter int unsigned HOLD_CYCLES = HOLD_S * CLK_HZ
) (
	// Clock and reset
	input  wire logic             i_clock,
	input  wire logic             i_arst_n,
	// Operator keypad
	input  wire keys_s            i_keys,
	// Bilge I/O units
	input  wire logic [NCH-1:0]   i_sensor,
	input  wire logic [NCH-1:0]   i_current_ok,
	input  wire logic [NCH-1:0]   i_manual_pump,
	input  wire logic             i_sense_jumper,
	output logic      [NCH-1:0]   o_pump_on,
	output logic      [NCH-1:0]   o_pump_fault,
	output logic      [NCH-1:0]   o_run_alarm,
	output logic                  o_alarm,
	// Display and storage
	output logic                  o_program_mode,
	output menu_e                 o_menu_state,
	output logic      [1:0]       o_menu_item,
	output logic      [3:0]       o_cur_addr,
	output logic      [2:0]       o_edit_pos,
	output logic                  o_nvm_save,
	// APB slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam int unsigned NSYNC = 6 + 3 * NCH + 1;
	logic [NSYNC-1:0] sync1_q, sync2_q;
	keys_s            key_q, key_prev_q, press;
	logic [NCH-1:0]   sensor, cur_ok, manual;
	logic             jumper;

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {i_keys, i_sensor, i_current_ok, i_manual_pump, i_sense_jumper};
			sync2_q <= sync1_q;
		end
	end

	assign {key_q, sensor, cur_ok, manual, jumper} = sync2_q;

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			key_prev_q <= '0;
		end else begin
			key_prev_q <= key_q;
		end
	end

	assign press = key_q & ~key_prev_q;

	// ----------------------------------------
	// Timebase and program-mode hold
	// ----------------------------------------
	logic [31:0] div_q, hold_q;
	logic        sec_tick;
	logic        hold_done;

	assign sec_tick  = (div_q == 32'(SEC_CYCLES - 1));
	assign hold_done = (hold_q == 32'(HOLD_CYCLES - 1));

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			div_q <= '0;
		end else begin
			div_q <= sec_tick ? '0 : div_q + 32'h1;
		end
	end

	// Any release restarts the hold, so it must be continuous
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			hold_q <= '0;
		end else if (key_q.mute && key_q.up && !hold_done) begin
			hold_q <= hold_q + 32'h1;
		end else if (!(key_q.mute && key_q.up)) begin
			hold_q <= '0;
		end
	end

	// ----------------------------------------
	// Menu state machine and working storage
	// ----------------------------------------
	menu_e          state_q;
	logic [1:0]     item_q, sub_item_q;
	logic           sub_q;
	logic [3:0]     addr_q;
	logic [2:0]     pos_q;
	logic           save_q;
	chan_s          cfg_q [NCH];
	logic [2:0]     ci;
	logic [5:0]     char_lsb;

	assign ci       = chan_idx(addr_q);
	assign char_lsb = 6'(pos_q) * 6'h06;

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_q    <= ST_MONITOR;
			item_q     <= ITEM_PROG;
			sub_item_q <= SUB_ON;
			sub_q      <= 1'b0;
			addr_q     <= MIN_ADDR;
			pos_q      <= '0;
			save_q     <= 1'b0;
			for (int i = 0; i < NCH; i++) begin
				cfg_q[i] <= '0;
			end
		end else begin
			save_q <= 1'b0;
			unique case (state_q)
			ST_MONITOR: begin
				if (hold_done) begin
					state_q <= ST_MENU;
					item_q  <= ITEM_PROG;
				end
			end
			ST_MENU: begin
				if (press.down) begin
					item_q <= item_q + 2'h1;
				end else if (press.up) begin
					item_q <= item_q - 2'h1;
				end else if (press.mute) begin
					unique case (item_q)
					ITEM_PROG:  begin state_q <= ST_SEL_CH; sub_q <= 1'b0; end
					ITEM_SUB:   begin state_q <= ST_SEL_CH; sub_q <= 1'b1; end
					ITEM_ERASE: state_q <= ST_ERASE_SEL;
					ITEM_EXIT:  begin state_q <= ST_MONITOR; save_q <= 1'b1; end
					endcase
				end
			end
			ST_SEL_CH, ST_ERASE_SEL: begin
				// Address stays within the 2..9 switch range
				if (press.up && addr_q != MAX_ADDR) begin
					addr_q <= addr_q + 4'h1;
				end else if (press.down && addr_q != MIN_ADDR) begin
					addr_q <= addr_q - 4'h1;
				end else if (press.mute) begin
					if (state_q == ST_ERASE_SEL) begin
						state_q <= ST_ERASE_CONF;
					end else if (sub_q) begin
						state_q    <= ST_SUB_MENU;
						sub_item_q <= SUB_ON;
					end else begin
						state_q <= ST_SEL_NAME;
					end
				end
			end
			ST_SEL_NAME: begin
				if (press.up) begin
					cfg_q[ci].preset <= (cfg_q[ci].preset == LAST_PRESET) ? 4'h0 : cfg_q[ci].preset + 4'h1;
					cfg_q[ci].custom <= 1'b0;
				end else if (press.down) begin
					cfg_q[ci].preset <= (cfg_q[ci].preset == 4'h0) ? LAST_PRESET : cfg_q[ci].preset - 4'h1;
					cfg_q[ci].custom <= 1'b0;
				end else if (press.mute) begin
					state_q <= ST_ON_PROMPT;
				end else if (press.pump) begin
					state_q          <= ST_EDIT_NAME;
					cfg_q[ci].custom <= 1'b1;
					pos_q            <= '0;
				end
			end
			ST_EDIT_NAME: begin
				if (press.dim_up && pos_q != LAST_POS) begin
					pos_q <= pos_q + 3'h1;
				end else if (press.dim_down && pos_q != 3'h0) begin
					pos_q <= pos_q - 3'h1;
				end else if (press.up) begin
					cfg_q[ci].text[char_lsb +: 6] <= cfg_q[ci].text[char_lsb +: 6] + 6'h01;
				end else if (press.down) begin
					cfg_q[ci].text[char_lsb +: 6] <= cfg_q[ci].text[char_lsb +: 6] - 6'h01;
				end else if (press.mute) begin
					state_q <= ST_ON_PROMPT;
				end
			end
			ST_ON_PROMPT, ST_OFF_PROMPT, ST_RUN_PROMPT: begin
				if (press.up || press.down) begin
					cfg_q[ci].on_s    <= DEF_ON_S;
					cfg_q[ci].off_s   <= DEF_OFF_S;
					cfg_q[ci].run_sec <= DEF_RUN_SEC;
					cfg_q[ci].run_min <= DEF_RUN_MIN;
					cfg_q[ci].valid   <= 1'b1;
					state_q           <= sub_q ? ST_SUB_MENU : ST_DONE;
				end else if (press.mute) begin
					unique case (state_q)
					ST_ON_PROMPT:  state_q <= ST_ON_EDIT;
					ST_OFF_PROMPT: state_q <= ST_OFF_EDIT;
					default:       state_q <= ST_RUN_SEC;
					endcase
				end
			end
			ST_ON_EDIT: begin
				if (press.up) begin
					cfg_q[ci].on_s <= sat_up(cfg_q[ci].on_s, STEP_S, MAX_DLY);
				end else if (press.down) begin
					cfg_q[ci].on_s <= sat_dn(cfg_q[ci].on_s, STEP_S);
				end else if (press.mute) begin
					state_q <= sub_q ? ST_SUB_MENU : ST_OFF_PROMPT;
				end
			end
			ST_OFF_EDIT: begin
				if (press.up) begin
					cfg_q[ci].off_s <= sat_up(cfg_q[ci].off_s, STEP_S, MAX_DLY);
				end else if (press.down) begin
					cfg_q[ci].off_s <= sat_dn(cfg_q[ci].off_s, STEP_S);
				end else if (press.mute) begin
					state_q <= sub_q ? ST_SUB_MENU : ST_RUN_PROMPT;
				end
			end
			ST_RUN_SEC: begin
				if (press.up) begin
					cfg_q[ci].run_sec <= 6'(sat_up({2'h0, cfg_q[ci].run_sec}, STEP_S, {2'h0, MAX_RUN_SEC}));
				end else if (press.down) begin
					cfg_q[ci].run_sec <= 6'(sat_dn({2'h0, cfg_q[ci].run_sec}, STEP_S));
				end else if (press.mute) begin
					state_q <= ST_RUN_MIN;
				end
			end
			ST_RUN_MIN: begin
				if (press.up) begin
					cfg_q[ci].run_min <= sat_up(cfg_q[ci].run_min, STEP_MIN, MAX_DLY);
				end else if (press.down) begin
					cfg_q[ci].run_min <= sat_dn(cfg_q[ci].run_min, STEP_MIN);
				end else if (press.mute) begin
					cfg_q[ci].valid <= 1'b1;
					state_q         <= sub_q ? ST_SUB_MENU : ST_DONE;
				end
			end
			ST_DONE: begin
				if (press.up) begin
					state_q <= ST_MENU;
				end else if (press.down) begin
					state_q <= ST_MONITOR;
					save_q  <= 1'b1;
				end
			end
			ST_ERASE_CONF: begin
				if (press.down) begin
					cfg_q[ci] <= '0;
					state_q   <= ST_MENU;
				end else if (press.up) begin
					state_q <= ST_MENU;
				end
			end
			ST_SUB_MENU: begin
				if (press.down) begin
					sub_item_q <= sub_item_q + 2'h1;
				end else if (press.up) begin
					sub_item_q <= sub_item_q - 2'h1;
				end else if (press.mute) begin
					unique case (sub_item_q)
					SUB_ON:   state_q <= ST_ON_PROMPT;
					SUB_OFF:  state_q <= ST_OFF_PROMPT;
					SUB_RUN:  state_q <= ST_RUN_PROMPT;
					SUB_EXIT: state_q <= ST_MENU;
					endcase
				end
			end
			endcase
		end
	end

	// ----------------------------------------
	// Per-channel pump timing and checking
	// ----------------------------------------
	logic            chk_en;
	logic [NCH-1:0]  pump_q, fault_q, run_alm_q, new_event;

	assign chk_en = !jumper;

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_chan
			logic [8:0]  on_cnt_q, off_cnt_q;
			logic [13:0] run_cnt_q, run_lim;
			logic [1:0]  settle_q;
			logic        cmd;

			assign run_lim = 14'(cfg_q[g].run_min * SEC_PER_MIN) + 14'(cfg_q[g].run_sec);
			assign cmd     = pump_q[g] || manual[g];

			// Sensor counts are per second and restart on any change of level
			// Strictly past the delay: the first tick may come at once
			always_ff @(posedge i_clock or negedge i_arst_n) begin
				if (!i_arst_n) begin
					pump_q[g] <= 1'b0;
					on_cnt_q  <= '0;
					off_cnt_q <= '0;
				end else if (!cfg_q[g].valid) begin
					pump_q[g] <= 1'b0;
					on_cnt_q  <= '0;
					off_cnt_q <= '0;
				end else if (sensor[g]) begin
					off_cnt_q <= '0;
					if (on_cnt_q > {1'b0, cfg_q[g].on_s}) begin
						pump_q[g] <= 1'b1;
					end else if (sec_tick) begin
						on_cnt_q <= on_cnt_q + 9'h1;
					end
				end else begin
					on_cnt_q <= '0;
					if (off_cnt_q > {1'b0, cfg_q[g].off_s}) begin
						pump_q[g] <= 1'b0;
					end else if (sec_tick) begin
						off_cnt_q <= off_cnt_q + 9'h1;
					end
				end
			end

			always_ff @(posedge i_clock or negedge i_arst_n) begin
				if (!i_arst_n) begin
					run_cnt_q    <= '0;
					run_alm_q[g] <= 1'b0;
				end else if (!cmd || !cfg_q[g].valid) begin
					run_cnt_q    <= '0;
					run_alm_q[g] <= 1'b0;
				end else if (run_cnt_q > run_lim) begin
					run_alm_q[g] <= 1'b1;
				end else if (sec_tick) begin
					run_cnt_q <= run_cnt_q + 14'h1;
				end
			end

			// Current needs a moment to build after switch-on
			always_ff @(posedge i_clock or negedge i_arst_n) begin
				if (!i_arst_n) begin
					settle_q   <= '0;
					fault_q[g] <= 1'b0;
				end else if (!cmd || !chk_en) begin
					settle_q   <= '0;
					fault_q[g] <= 1'b0;
				end else if (settle_q != 2'(SETTLE_S)) begin
					settle_q <= sec_tick ? settle_q + 2'h1 : settle_q;
				end else if (!cur_ok[g]) begin
					fault_q[g] <= 1'b1;
				end
			end

			assign new_event[g] = (fault_q[g] && !o_pump_fault[g]) || (run_alm_q[g] && !o_run_alarm[g]);
		end
	endgenerate

	// ----------------------------------------
	// Audible alarm
	// ----------------------------------------
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_alarm <= 1'b0;
		end else if (|new_event) begin
			o_alarm <= 1'b1;
		end else if (press.mute) begin
			o_alarm <= 1'b0;
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pump_on      <= '0;
			o_pump_fault   <= '0;
			o_run_alarm    <= '0;
			o_program_mode <= 1'b0;
			o_menu_state   <= ST_MONITOR;
			o_menu_item    <= '0;
			o_cur_addr     <= MIN_ADDR;
			o_edit_pos     <= '0;
			o_nvm_save     <= 1'b0;
		end else begin
			o_pump_on      <= pump_q | manual;
			o_pump_fault   <= fault_q;
			o_run_alarm    <= run_alm_q;
			o_program_mode <= (state_q != ST_MONITOR);
			o_menu_state   <= state_q;
			o_menu_item    <= (state_q == ST_SUB_MENU) ? sub_item_q : item_q;
			o_cur_addr     <= addr_q;
			o_edit_pos     <= pos_q;
			o_nvm_save     <= save_q;
		end
	end

	// ----------------------------------------
	// APB register file
	// ----------------------------------------
	logic [2:0] chsel_q;
	logic       hit;
	chan_s      rc;
	logic [5:0] cur_char;

	assign rc       = cfg_q[chsel_q];
	assign cur_char = cfg_q[ci].text[char_lsb +: 6];
	assign hit     = paddr == REG_STATUS || paddr == REG_CHSEL || paddr == REG_CHCFG || paddr == REG_PUMPS;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit;

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			chsel_q <= '0;
		end else if (psel && penable && pwrite && paddr == REG_CHSEL) begin
			chsel_q <= pwdata[2:0];
		end
	end

	// Read data captured in the setup cycle, so the access phase needs no wait
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			prdata <= '0;
		end else if (psel && !penable) begin
			unique case (paddr)
			REG_STATUS: prdata <= {14'h0, cur_char, rc.custom, rc.preset, chk_en, o_alarm, o_program_mode, state_q};
			REG_CHSEL:  prdata <= {29'h0, chsel_q};
			REG_CHCFG:  prdata <= {rc.run_min, rc.valid, 1'b0, rc.run_sec, rc.off_s, rc.on_s};
			REG_PUMPS:  prdata <= {8'h0, run_alm_q, fault_q, pump_q};
			default:    prdata <= '0;
			endcase
		end
	end

endmodule

`default_nettype wire
